// >>> shared/dlr_map.svh
/*
 Offsets, field positions, reset values and timing counts of the log-read block.
 Assumes inclusion by the design module only.
*/
`ifndef DLR_MAP_SVH
`define DLR_MAP_SVH
`define DLR_A_FEAT      8'h00
`define DLR_A_CNT       8'h04
`define DLR_A_SEC       8'h08
`define DLR_A_CYL       8'h0C
`define DLR_A_CYH       8'h10
`define DLR_A_DH        8'h14
`define DLR_A_CTL       8'h18
`define DLR_A_CMD       8'h1C
`define DLR_A_ERR       8'h20
`define DLR_A_DATA      8'h24
`define DLR_A_CFG       8'h28
`define DLR_A_LIFE      8'h2C
`define DLR_A_ERR_EV    8'h30
`define DLR_A_ST_EV     8'h34
`define DLR_A_LBA_LO    8'h38
`define DLR_A_LBA_HI    8'h3C
`define DLR_A_INFO      8'h40
`define DLR_CMD_RDLOG   8'h2F
`define DLR_HOB_BIT     7
`define DLR_ABT_BIT     2
`define DLR_CFG_SMART   0
`define DLR_CFG_SELF    1
`define DLR_CFG_RST     2'h3
`define DLR_LOG_DIR     8'h00
`define DLR_LOG_ERR     8'h03
`define DLR_LOG_OLDST   8'h06
`define DLR_LOG_ST      8'h07
`define DLR_HOST_LEN    16'h0010
`define DLR_DIR_VER     16'h0001
`define DLR_LOG_VER     8'h01
`define DLR_ERR_BASE    9'h004
`define DLR_ERR_LEN     9'd124
`define DLR_ERR_CNT     9'h1F4
`define DLR_ERR_MAX     3'd4
`define DLR_ST_BASE     9'h004
`define DLR_ST_LEN      9'd26
`define DLR_ST_MAX      5'd18
`define DLR_STAMP_MS    1
`define DLR_CLK_NS      5
`define DLR_MS_CYCLES   (`DLR_STAMP_MS * 1000000 / `DLR_CLK_NS)
`endif

// >>> shared/dlr_pkg.sv
/*
 Types of the log-read block.
 Assumes the constants header sits beside it.
*/
package dlr_pkg;
    typedef enum logic {DLR_IDLE, DLR_XFER} dlr_state_e;
    typedef logic [7:0] dlr_byte_t;
    typedef struct packed {
        logic [15:0]      life;
        logic [3:0]       state;
        dlr_byte_t        stat;
        dlr_byte_t        err;
        logic [31:0]      stamp;
        logic [12:0][7:0] tf;
    } dlr_err_s;
    typedef struct packed {
        logic [47:0] lba;
        dlr_byte_t   chk;
        logic [15:0] hours;
        dlr_byte_t   status;
        dlr_byte_t   num;
    } dlr_st_s;
endpackage

// >>> hdl/dlr_log_read.sv
/*
 Log-read command handler with its error and self-test logs, on an APB slave.
 Assumes firmware reports errors and self-tests through event registers.
*/
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dlr_map.svh"
module dlr_log_read #(
    parameter int MS_CYCLES = `DLR_MS_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             intrq
);
    import dlr_pkg::*;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // =====================================================
    // Declarations
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        intrq_q;
    dlr_state_e  state_q;
    dlr_byte_t   feat_q;
    dlr_byte_t   featp_q;
    dlr_byte_t   cnt_q;
    dlr_byte_t   cntp_q;
    dlr_byte_t   sec_q;
    dlr_byte_t   secp_q;
    dlr_byte_t   cyl_q;
    dlr_byte_t   cylp_q;
    dlr_byte_t   cyh_q;
    dlr_byte_t   cyhp_q;
    dlr_byte_t   dh_q;
    dlr_byte_t   ctl_q;
    dlr_byte_t   cmd_q;
    dlr_byte_t   err_q;
    logic        errb_q;
    dlr_byte_t   log_q;
    logic [15:0] cur_q;
    logic [15:0] left_q;
    logic [7:0]  word_q;
    dlr_byte_t   sum_q;
    logic [1:0]  cfg_q;
    logic [15:0] life_q;
    logic [31:0] lba_lo_q;
    logic [15:0] lba_hi_q;
    logic [31:0] pre_q;
    logic [31:0] ms_q;
    dlr_err_s    err_mem_q [`DLR_ERR_MAX];
    logic [2:0]  err_idx_q;
    logic [15:0] err_cnt_q;
    dlr_st_s     st_mem_q [`DLR_ST_MAX];
    logic [4:0]  st_idx_q;
    logic        setup;
    logic        wr;
    logic        rd;
    logic [15:0] log_len;
    logic        feat_ok;
    logic [15:0] req_cnt;
    logic [15:0] first;
    logic        cmd_ok;
    logic        csum_log;
    dlr_byte_t   lo_b;
    dlr_byte_t   hi_b;
    logic [15:0] data_w;
    logic [31:0] rdata_c;
    logic        hit_c;
    logic        err_ev;
    logic        st_ev;
    logic [2:0]  err_nx;
    logic [4:0]  st_nx;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign intrq   = intrq_q;

    assign setup = psel && !penable;
    assign wr    = psel && penable && pready_q && pwrite;
    assign rd    = psel && penable && pready_q && !pwrite;

    // =====================================================
    // Command decode and parameter checks
    assign req_cnt = {secp_q, cnt_q};
    assign first   = {cylp_q, cyl_q};

    always_comb begin
        log_len = 16'h0000;
        feat_ok = 1'b0;
        // The log address comes from the current sector field.
        if (sec_q == `DLR_LOG_DIR) begin
            log_len = 16'h0001;
            feat_ok = 1'b1;
        end else if (sec_q == `DLR_LOG_ERR) begin
            log_len = 16'h0001;
            feat_ok = cfg_q[`DLR_CFG_SMART];
        end else if (sec_q == `DLR_LOG_ST) begin
            log_len = 16'h0001;
            feat_ok = cfg_q[`DLR_CFG_SELF];
        end else if (sec_q[7:5] == 3'h4) begin
            log_len = `DLR_HOST_LEN;
            feat_ok = cfg_q[`DLR_CFG_SMART];
        end
        // The legacy self-test log falls through with no length.
    end

    assign cmd_ok = feat_ok && (req_cnt != 16'h0000) && (first < log_len)
                    && ({1'b0, first} + {1'b0, req_cnt} <= {1'b0, log_len});

    assign csum_log = (log_q == `DLR_LOG_ERR) || (log_q == `DLR_LOG_ST);

    // =====================================================
    // Sector byte generator
    function automatic dlr_byte_t byte_at(input dlr_byte_t lg, input logic [8:0] off);
        logic [8:0]   eo;
        logic [1:0]   e;
        logic [6:0]   f;
        logic [4:0]   d;
        logic [4:0]   g;
        logic [991:0] ent;
        logic [207:0] desc;
        dlr_err_s     er;
        byte_at = 8'h00;
        eo      = off - `DLR_ERR_BASE;
        e       = 2'(eo / `DLR_ERR_LEN);
        f       = 7'(eo - {7'h00, e} * `DLR_ERR_LEN);
        d       = 5'((off - `DLR_ST_BASE) / `DLR_ST_LEN);
        g       = 5'((off - `DLR_ST_BASE) - {4'h0, d} * `DLR_ST_LEN);
        er      = err_mem_q[e];
        // Four earlier command records stay zero; the last sits at 48h.
        ent = {er.life, 4'h0, er.state, 152'h0, er.stat, er.tf[11], er.tf[10:3],
               er.err, 8'h00, er.stamp, 8'h00, er.tf[12:0], 576'h0};
        desc = {120'h0, st_mem_q[(d < `DLR_ST_MAX) ? d : 5'd0]};
        if (lg == `DLR_LOG_DIR) begin
            if (off == 9'h000) begin
                byte_at = 8'(`DLR_DIR_VER);
            end else if (!off[0] && (off[8:1] == `DLR_LOG_ERR || off[8:1] == `DLR_LOG_ST)) begin
                byte_at = 8'h01;
            end else if (!off[0] && off[8:6] == 3'h4) begin
                byte_at = 8'(`DLR_HOST_LEN);
            end
        end else if (lg == `DLR_LOG_ERR) begin
            if (off == 9'h000) begin
                byte_at = `DLR_LOG_VER;
            end else if (off == 9'h002) begin
                byte_at = {5'h00, err_idx_q};
            end else if (off == `DLR_ERR_CNT) begin
                byte_at = err_cnt_q[7:0];
            end else if (off == `DLR_ERR_CNT + 9'h001) begin
                byte_at = err_cnt_q[15:8];
            end else if (off >= `DLR_ERR_BASE && off < `DLR_ERR_CNT) begin
                byte_at = ent[{f, 3'h0} +: 8];
            end
        end else if (lg == `DLR_LOG_ST) begin
            if (off == 9'h000) begin
                byte_at = `DLR_LOG_VER;
            end else if (off == 9'h002) begin
                byte_at = {3'h0, st_idx_q};
            end else if (off >= `DLR_ST_BASE && d < `DLR_ST_MAX) begin
                byte_at = desc[{g, 3'h0} +: 8];
            end
        end
    endfunction

    always_comb begin
        lo_b = byte_at(log_q, {word_q, 1'b0});
        hi_b = byte_at(log_q, {word_q, 1'b1});
        if (csum_log && word_q == 8'hFF) begin
            hi_b = 8'(8'h00 - sum_q - lo_b);
        end
        data_w = {hi_b, lo_b};
    end

    // =====================================================
    // APB read mux and response
    always_comb begin
        rdata_c = 32'h0000_0000;
        hit_c   = 1'b1;
        case (paddr)
            `DLR_A_FEAT:   rdata_c[7:0] = ctl_q[`DLR_HOB_BIT] ? featp_q : feat_q;
            `DLR_A_CNT:    rdata_c[7:0] = ctl_q[`DLR_HOB_BIT] ? cntp_q : cnt_q;
            `DLR_A_SEC:    rdata_c[7:0] = ctl_q[`DLR_HOB_BIT] ? secp_q : sec_q;
            `DLR_A_CYL:    rdata_c[7:0] = ctl_q[`DLR_HOB_BIT] ? cylp_q : cyl_q;
            `DLR_A_CYH:    rdata_c[7:0] = ctl_q[`DLR_HOB_BIT] ? cyhp_q : cyh_q;
            `DLR_A_DH:     rdata_c[7:0] = dh_q;
            `DLR_A_CTL:    rdata_c[7:0] = ctl_q;
            `DLR_A_CMD:    rdata_c[7:0] = {4'h5, state_q == DLR_XFER, 2'h0, errb_q};
            `DLR_A_ERR:    rdata_c[7:0] = err_q;
            `DLR_A_DATA:   rdata_c[15:0] = (state_q == DLR_XFER) ? data_w : 16'h0000;
            `DLR_A_CFG:    rdata_c[1:0] = cfg_q;
            `DLR_A_LIFE:   rdata_c[15:0] = life_q;
            `DLR_A_ERR_EV: rdata_c = 32'h0000_0000;
            `DLR_A_ST_EV:  rdata_c = 32'h0000_0000;
            `DLR_A_LBA_LO: rdata_c = lba_lo_q;
            `DLR_A_LBA_HI: rdata_c[15:0] = lba_hi_q;
            `DLR_A_INFO:   rdata_c = {err_cnt_q, 3'h0, st_idx_q, 5'h00, err_idx_q};
            default:       hit_c = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit_c;
            if (setup && !pwrite) begin
                prdata_q <= rdata_c;
            end
        end
    end

    // =====================================================
    // Task-file registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {feat_q, featp_q, cnt_q, cntp_q, sec_q, secp_q} <= 48'h0;
            {cyl_q, cylp_q, cyh_q, cyhp_q, dh_q, ctl_q, cmd_q} <= 56'h0;
        end else if (wr && state_q == DLR_IDLE) begin
            case (paddr)
                `DLR_A_FEAT: {featp_q, feat_q} <= {feat_q, pwdata[7:0]};
                `DLR_A_CNT:  {cntp_q, cnt_q} <= {cnt_q, pwdata[7:0]};
                `DLR_A_SEC:  {secp_q, sec_q} <= {sec_q, pwdata[7:0]};
                `DLR_A_CYL:  {cylp_q, cyl_q} <= {cyl_q, pwdata[7:0]};
                `DLR_A_CYH:  {cyhp_q, cyh_q} <= {cyh_q, pwdata[7:0]};
                `DLR_A_DH:   dh_q <= pwdata[7:0];
                `DLR_A_CTL:  ctl_q <= pwdata[7:0];
                `DLR_A_CMD:  cmd_q <= pwdata[7:0];
                default:     ;
            endcase
        end
    end

    // =====================================================
    // Command execution and data-in transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DLR_IDLE;
            intrq_q <= 1'b0;
            err_q   <= 8'h00;
            errb_q  <= 1'b0;
            log_q   <= 8'h00;
            cur_q   <= 16'h0000;
            left_q  <= 16'h0000;
            word_q  <= 8'h00;
            sum_q   <= 8'h00;
        end else begin
            if (rd && paddr == `DLR_A_CMD) begin
                intrq_q <= 1'b0;
            end
            unique case (state_q)
                DLR_IDLE: begin
                    if (wr && paddr == `DLR_A_CMD) begin
                        intrq_q <= 1'b1;
                        if (pwdata[7:0] == `DLR_CMD_RDLOG && cmd_ok) begin
                            state_q <= DLR_XFER;
                            log_q   <= sec_q;
                            cur_q   <= first;
                            left_q  <= req_cnt;
                            word_q  <= 8'h00;
                            sum_q   <= 8'h00;
                            err_q   <= 8'h00;
                            errb_q  <= 1'b0;
                        end else begin
                            err_q  <= 8'h01 << `DLR_ABT_BIT;
                            errb_q <= 1'b1;
                        end
                    end
                end
                DLR_XFER: begin
                    if (rd && paddr == `DLR_A_DATA) begin
                        word_q <= 8'(word_q + 8'h01);
                        sum_q  <= 8'(sum_q + lo_b + hi_b);
                        if (word_q == 8'hFF) begin
                            sum_q  <= 8'h00;
                            left_q <= 16'(left_q - 16'h0001);
                            cur_q  <= 16'(cur_q + 16'h0001);
                            if (left_q == 16'h0001) begin
                                state_q <= DLR_IDLE;
                            end else begin
                                intrq_q <= 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // =====================================================
    // Configuration, stamps and event staging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q    <= `DLR_CFG_RST;
            life_q   <= 16'h0000;
            lba_lo_q <= 32'h0000_0000;
            lba_hi_q <= 16'h0000;
        end else if (wr) begin
            case (paddr)
                `DLR_A_CFG:    cfg_q <= pwdata[1:0];
                `DLR_A_LIFE:   life_q <= pwdata[15:0];
                `DLR_A_LBA_LO: lba_lo_q <= pwdata;
                `DLR_A_LBA_HI: lba_hi_q <= pwdata[15:0];
                default:       ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 32'h0000_0000;
            ms_q  <= 32'h0000_0000;
        end else if (pre_q == 32'(MS_CYCLES - 1)) begin
            pre_q <= 32'h0000_0000;
            ms_q  <= 32'(ms_q + 32'h1);
        end else begin
            pre_q <= 32'(pre_q + 32'h1);
        end
    end

    // =====================================================
    // Error log upkeep
    assign err_ev = wr && paddr == `DLR_A_ERR_EV && !pwdata[24];
    assign err_nx = (err_idx_q == `DLR_ERR_MAX) ? 3'd1 : 3'(err_idx_q + 3'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_idx_q <= 3'd0;
            err_cnt_q <= 16'h0000;
            for (int i = 0; i < `DLR_ERR_MAX; i++) begin
                err_mem_q[i] <= '0;
            end
        end else if (err_ev) begin
            err_idx_q <= err_nx;
            if (err_cnt_q != 16'hFFFF) begin
                err_cnt_q <= 16'(err_cnt_q + 16'h0001);
            end
            err_mem_q[2'(err_nx - 3'd1)] <= '{life: life_q, state: pwdata[19:16],
                stat: pwdata[15:8], err: pwdata[7:0], stamp: ms_q,
                tf: {cmd_q, dh_q, cyhp_q, cyh_q, cylp_q, cyl_q, secp_q, sec_q,
                     cntp_q, cnt_q, featp_q, feat_q, ctl_q}};
        end
    end

    // =====================================================
    // Self-test log upkeep
    assign st_ev = wr && paddr == `DLR_A_ST_EV;
    assign st_nx = (st_idx_q == `DLR_ST_MAX) ? 5'd1 : 5'(st_idx_q + 5'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_idx_q <= 5'd0;
            for (int i = 0; i < `DLR_ST_MAX; i++) begin
                st_mem_q[i] <= '0;
            end
        end else if (st_ev) begin
            st_idx_q <= st_nx;
            st_mem_q[5'(st_nx - 5'd1)] <= '{lba: {lba_hi_q, lba_lo_q},
                chk: pwdata[23:16], hours: life_q, status: pwdata[15:8],
                num: pwdata[7:0]};
        end
    end

    // =====================================================
    // Assertions and covers
    logic [7:0] hsum_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsum_q <= 8'h00;
        end else if (rd && paddr == `DLR_A_DATA && state_q == DLR_XFER) begin
            hsum_q <= (word_q == 8'hFF) ? 8'h00 : 8'(hsum_q + prdata_q[7:0] + prdata_q[15:8]);
        end
    end

    chk_old_selftest: assert property (
        (wr && paddr == `DLR_A_CMD && state_q == DLR_IDLE && sec_q == `DLR_LOG_OLDST)
        |=> errb_q && err_q[`DLR_ABT_BIT] && state_q == DLR_IDLE)
        else $error("legacy self-test log not aborted");
    chk_block_intr: assert property (
        $rose(state_q == DLR_XFER) || (state_q == DLR_XFER && $changed(cur_q)) |-> intrq_q)
        else $error("data block without interrupt");
    chk_start_sector: assert property (
        (wr && paddr == `DLR_A_CMD && state_q == DLR_IDLE && pwdata[7:0] == `DLR_CMD_RDLOG
         && cmd_ok) |=> cur_q == $past(first) && word_q == 8'h00)
        else $error("transfer does not start at first sector");
    chk_dir_version: assert property (
        (state_q == DLR_XFER && log_q == `DLR_LOG_DIR && word_q == 8'h00) |-> data_w == 16'h0001)
        else $error("directory version wrong");
    chk_dir_host_len: assert property (
        (state_q == DLR_XFER && log_q == `DLR_LOG_DIR && word_q[7:5] == 3'h4) |-> data_w == 16'h0010)
        else $error("host log length wrong in directory");
    chk_err_idx_range: assert property (err_idx_q <= 3'd4)
        else $error("error index out of range");
    chk_st_idx_range: assert property (st_idx_q <= 5'd18)
        else $error("self-test index out of range");
    chk_err_count_sat: assert property (
        err_ev |=> err_cnt_q == (($past(err_cnt_q) == 16'hFFFF) ? 16'hFFFF
                                 : 16'($past(err_cnt_q) + 16'h0001)))
        else $error("error count wrapped");
    chk_fault_skip: assert property (
        (wr && paddr == `DLR_A_ERR_EV && pwdata[24]) |=> $stable(err_idx_q) && $stable(err_cnt_q))
        else $error("faulty command logged");
    chk_err_wrap: assert property (
        (err_ev && err_idx_q == 3'd4) |=> err_idx_q == 3'd1 ##1 err_idx_q <= 3'd2)
        else $error("error log does not wrap");
    chk_sector_sum: assert property (
        (rd && paddr == `DLR_A_DATA && state_q == DLR_XFER && csum_log && word_q == 8'hFF)
        |-> 8'(hsum_q + prdata_q[7:0] + prdata_q[15:8]) == 8'h00)
        else $error("sector checksum wrong");

    cov_read_log: cover property ($rose(state_q == DLR_XFER) ##[1:1000] $fell(state_q == DLR_XFER));
    cov_abort: cover property (wr && paddr == `DLR_A_CMD ##1 errb_q);
    cov_st_wrap: cover property (st_ev && st_idx_q == 5'd18);
endmodule

// >>> dv/dlr_host.sv
/*
 Host adapter model: an APB master issuing task-file accesses.
 Assumes one clock and a slave that ends each access with pready.
*/
`timescale 1ns/1ps
module dlr_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata
);
    logic stalled = 1'b0;
    logic last_err = 1'b0;
    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
    end
    // ==========
    // Bus cycle: setup, then access held until pready, for at most 64 cycles.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        stalled = (n == 64);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

// >>> dv/dlr_log_read_bench.sv
/*
 Self-checking bench of the log-read block.
 Assumes the host model drives the APB side.
*/
`timescale 1ns/1ps
module dlr_log_read_bench;
    logic        pclk;
    logic        presetn = 1'b0;
    logic [7:0]  paddr;
    logic        psel, penable, pwrite, pready, pslverr, intrq;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] w [256];
    logic [7:0]  e8;
    int          fail_count = 0;
    int          total_checks = 0;
    int          seed = 13953;
    int          n, b;
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    dlr_log_read #(.MS_CYCLES(4)) i_dlr_log_read (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq));
    dlr_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic xf(input logic wr, input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(wr, a, d, q);
        if (u_host.stalled) begin
            fail_count++;
            stop_test();
        end
    endtask
    function automatic logic [7:0] bt(input int x);
        return x[0] ? w[x >> 1][15:8] : w[x >> 1][7:0];
    endfunction
    // ==========
    // Log read: load the task file, issue the command, then drain every sector or check the abort.
    task automatic run(input logic [7:0] l, input logic [15:0] c, input logic [15:0] f,
                       input logic ab);
        logic [7:0] s;
        int k, i;
        s = 8'h00;
        xf(1'b1, 8'h08, {24'h0, c[15:8]});
        xf(1'b1, 8'h08, {24'h0, l});
        xf(1'b1, 8'h04, {24'h0, c[7:0]});
        xf(1'b1, 8'h0C, {24'h0, f[15:8]});
        xf(1'b1, 8'h0C, {24'h0, f[7:0]});
        xf(1'b1, 8'h1C, 32'h2F);
        for (k = 0; k < c || k == 0; k++) begin
            @(posedge pclk);
            #1;
            chk("intrq", 1, intrq);
            xf(1'b0, 8'h1C, 0);
            chk("status", ab ? 8'h51 : 8'h58, q[7:0]);
            if (ab) begin
                xf(1'b0, 8'h20, 0);
                chk("error", 8'h04, q[7:0]);
                return;
            end
            for (i = 0; i < 256; i++) begin
                xf(1'b0, 8'h24, 0);
                w[i] = q[15:0];
                s += q[15:8] + q[7:0];
                if (l[7])
                    chk("host data", 0, q[15:0]);
            end
        end
        @(posedge pclk);
        #1;
        chk("last intrq", 0, intrq);
        xf(1'b0, 8'h1C, 0);
        chk("done", 8'h50, q[7:0]);
        if (l == 3 || l == 7)
            chk("sum", 0, s);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        xf(1'b0, 8'h7C, 0);
        chk("unmapped", 1, u_host.last_err);
        run(8'h06, 1, 0, 1);
        run(8'h03, 0, 0, 1);
        run(8'h80, 1, 16, 1);
        run(8'h05, 1, 0, 1);
        run(8'h07, 2, 0, 1);
        xf(1'b1, 8'h28, 0);
        run(8'h03, 1, 0, 1);
        xf(1'b1, 8'h28, 3);
        run(8'h00, 1, 0, 0);
        for (n = 0; n < 256; n++)
            chk("dir", (n == 0 || n == 3 || n == 7) ? 1 : (n >= 128 && n < 160) ? 16 : 0,
                w[n]);
        b = 8'h80 + ($random(seed) & 31);
        run(b[7:0], 2, 14, 0);
        run(8'h03, 1, 0, 0);
        chk("err ver", 1, w[0]);
        chk("err idx", 0, w[1]);
        chk("err slot", 0, w[2]);
        xf(1'b1, 8'h30, 32'h0100_0004);
        for (n = 1; n <= 5; n++) begin
            e8 = 8'($random(seed));
            xf(1'b1, 8'h30, {12'h0, 4'h3, 8'h51, e8});
            run(8'h03, 1, 0, 0);
            b = 4 + 124 * ((n - 1) % 4);
            chk("err idx", (n - 1) % 4 + 1, w[1]);
            chk("dev count", n, w[250]);
            chk("err code", e8, bt(b + 'h5B));
            chk("err stat", 8'h51, bt(b + 'h65));
            chk("state", 3, bt(b + 'h79) & 8'h0F);
            chk("command", 8'h2F, bt(b + 'h54));
            chk("err sector", 8'h03, bt(b + 'h5E));
        end
        xf(1'b0, 8'h40, 0);
        chk("info", 32'h0005_0001, q);
        xf(1'b1, 8'h18, 32'h80);
        xf(1'b0, 8'h08, 0);
        chk("hob sector", 0, q[7:0]);
        xf(1'b1, 8'h18, 0);
        xf(1'b0, 8'h08, 0);
        chk("sector", 3, q[7:0]);
        run(8'h07, 1, 0, 0);
        chk("st idx", 0, w[1]);
        xf(1'b1, 8'h2C, 32'h0000_0C35);
        chk("st slot", 0, w[2]);
        for (n = 1; n <= 19; n++) begin
            xf(1'b1, 8'h38, n * 32'h0101_0101);
            xf(1'b1, 8'h3C, 32'h0000_AB00 + n);
            xf(1'b1, 8'h34, {8'h0, 8'h5A, 8'h20, n[7:0]});
            if (n == 1 || n >= 18) begin
                run(8'h07, 1, 0, 0);
                b = 4 + 26 * ((n - 1) % 18);
                chk("st ver", 1, w[0]);
                chk("st idx", (n - 1) % 18 + 1, w[1]);
                chk("st num", n, bt(b));
                chk("st status", 8'h20, bt(b + 1));
                chk("st point", 8'h5A, bt(b + 4));
                chk("st hours", 16'h0C35, {bt(b + 3), bt(b + 2)});
                chk("st lba", {8'hAB, n[7:0]}, {bt(b + 10), bt(b + 5)});
            end
        end
        chk("st kept", 2, bt(30));
        stop_test();
    end
endmodule
